// ---- cidtm_mask_cmp.sv ----
// masked bitwise comparison of a received identifier field against a tag field
`timescale 1ns/1ps

module cidtm_mask_cmp #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // comparison request
    input wire logic cmp_req,
    input wire logic [WIDTH-1:0] rx_bits,
    input wire logic [WIDTH-1:0] tag_bits,
    input wire logic [WIDTH-1:0] mask_bits,
    // result
    output logic hit_ff,
    output logic done_ff
);

    logic [WIDTH-1:0] bit_ok;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            // mask zero forces a match, mask one demands equality
            assign bit_ok[gi] = ~mask_bits[gi] | (rx_bits[gi] == tag_bits[gi]);
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hit_ff <= 1'b0;
        end else if (cmp_req) begin
            hit_ff <= &bit_ok;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= cmp_req;
        end
    end

endmodule : cidtm_mask_cmp

// ---- cidtm_params.svh ----
// address map, field positions and layout masks of the identifier tag/mask bank
`ifndef CIDTM_PARAMS_SVH
`define CIDTM_PARAMS_SVH

// special-function-register addresses
`define CIDTM_ADDR_TAG_ONE 8'hBC
`define CIDTM_ADDR_TAG_TWO 8'hBD
`define CIDTM_ADDR_TAG_THREE 8'hBE
`define CIDTM_ADDR_TAG_FOUR 8'hBF
`define CIDTM_ADDR_MASK_ONE 8'hC4

// bits that carry information in the standard (11-bit) layout
`define CIDTM_STD_KEEP_TAG_ONE 8'hFF
`define CIDTM_STD_KEEP_TAG_TWO 8'hE0
`define CIDTM_STD_KEEP_TAG_THREE 8'h00
`define CIDTM_STD_KEEP_TAG_FOUR 8'h05
`define CIDTM_STD_KEEP_MASK_ONE 8'hFF

// bits that carry information in the extended (29-bit) layout
`define CIDTM_EXT_KEEP_ALL 8'hFF

// flag positions inside tag register four
`define CIDTM_BIT_RTR 2
`define CIDTM_BIT_RB1 1
`define CIDTM_BIT_RB0 0

// identifier bits 2:0 (std) and 4:0 (ext) field in tag registers two / four
`define CIDTM_STD_LOW_MSB 7
`define CIDTM_STD_LOW_LSB 5
`define CIDTM_EXT_LOW_MSB 7
`define CIDTM_EXT_LOW_LSB 3

// idle values
`define CIDTM_BYTE_ZERO 8'h00
`define CIDTM_ID_ZERO 29'h0000000
`define CIDTM_STD_PAD 18'h00000

`endif

// ---- cidtm_pkg.sv ----
// types shared by the identifier tag/mask bank
package cidtm_pkg;

    typedef logic [7:0] cidtm_byte_t;

    // register slot selected by an SFR address, one-hot
    typedef enum logic [5:0] {
        CIDTM_SLOT_NONE = 6'h01,
        CIDTM_SLOT_TAG1 = 6'h02,
        CIDTM_SLOT_TAG2 = 6'h04,
        CIDTM_SLOT_TAG3 = 6'h08,
        CIDTM_SLOT_TAG4 = 6'h10,
        CIDTM_SLOT_MSK1 = 6'h20
    } cidtm_slot_e;

    // frame format of the selected message object, one-hot
    typedef enum logic [1:0] {
        CIDTM_FMT_STD = 2'h1,
        CIDTM_FMT_EXT = 2'h2
    } cidtm_fmt_e;

endpackage : cidtm_pkg

// ---- cidtm_regs.sv ----
// identifier tag and mask register bank for the selected CAN message object
//
// Contract
// - std tag one holds id 10:3
// - std tag two holds id 2:0, rest reserved
// - reserved bits read undefined, never written one
// - std tag three is wholly reserved
// - std tag four: remote tag bit2, rb0 bit0
// - ext tag one holds id 28:21
// - ext tag two holds id 20:13
// - ext tag three holds id 12:5
// - ext tag four: id 4:0, rtr, rb1, rb0
// - std mask one masks id 10:3
// - mask zero forces match, one compares bit
// - no reset value, software loads first
`timescale 1ns/1ps
`include "cidtm_params.svh"

module cidtm_regs #(
    parameter int NUM_OBJ = 15,
    parameter int OBJ_W = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // special-function-register access
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata_ff,
    output logic sfr_hit,
    // message object selection and its configured frame format
    input wire logic [OBJ_W-1:0] obj_sel,
    input wire logic obj_ext_fmt,
    // acceptance comparison of identifier top byte
    input wire logic rx_cmp_req,
    input wire logic [7:0] rx_id_top,
    output logic id_top_match_ff,
    output logic id_top_match_valid_ff,
    // tag and mask of the selected object, as seen by the frame datapath
    output logic [28:0] sel_identifier_tag_bits_ff,
    output logic sel_remote_request_tag_ff,
    output logic sel_reserved_bit1_tag_ff,
    output logic sel_reserved_bit0_tag_ff,
    output logic [7:0] sel_identifier_mask_bits_std_ff
);

    // storage per message object; no reset, contents are undefined until loaded
    cidtm_pkg::cidtm_byte_t tag_one_mem [0:NUM_OBJ-1];
    cidtm_pkg::cidtm_byte_t tag_two_mem [0:NUM_OBJ-1];
    cidtm_pkg::cidtm_byte_t tag_three_mem [0:NUM_OBJ-1];
    cidtm_pkg::cidtm_byte_t tag_four_mem [0:NUM_OBJ-1];
    cidtm_pkg::cidtm_byte_t mask_one_mem [0:NUM_OBJ-1];

    cidtm_pkg::cidtm_fmt_e cur_fmt;
    cidtm_pkg::cidtm_slot_e wr_slot;
    cidtm_pkg::cidtm_slot_e rd_slot;
    logic obj_ok;
    cidtm_pkg::cidtm_byte_t cur_tag_one;
    cidtm_pkg::cidtm_byte_t cur_tag_two;
    cidtm_pkg::cidtm_byte_t cur_tag_three;
    cidtm_pkg::cidtm_byte_t cur_tag_four;
    cidtm_pkg::cidtm_byte_t cur_mask_one;
    cidtm_pkg::cidtm_byte_t wr_keep;
    cidtm_pkg::cidtm_byte_t nxt_rdata;
    logic [28:0] nxt_id;
    logic nxt_rb1;

    // address decode, shared by the write and the read path
    function automatic cidtm_pkg::cidtm_slot_e slot_of(input logic [7:0] addr);
        case (addr)
            `CIDTM_ADDR_TAG_ONE: slot_of = cidtm_pkg::CIDTM_SLOT_TAG1;
            `CIDTM_ADDR_TAG_TWO: slot_of = cidtm_pkg::CIDTM_SLOT_TAG2;
            `CIDTM_ADDR_TAG_THREE: slot_of = cidtm_pkg::CIDTM_SLOT_TAG3;
            `CIDTM_ADDR_TAG_FOUR: slot_of = cidtm_pkg::CIDTM_SLOT_TAG4;
            `CIDTM_ADDR_MASK_ONE: slot_of = cidtm_pkg::CIDTM_SLOT_MSK1;
            default: slot_of = cidtm_pkg::CIDTM_SLOT_NONE;
        endcase
    endfunction : slot_of

    // bits of a slot that carry information in the given layout
    function automatic cidtm_pkg::cidtm_byte_t keep_of(input cidtm_pkg::cidtm_slot_e slot,
                                                       input cidtm_pkg::cidtm_fmt_e fmt);
        if (fmt == cidtm_pkg::CIDTM_FMT_EXT) begin
            case (slot)
                cidtm_pkg::CIDTM_SLOT_TAG1: keep_of = `CIDTM_EXT_KEEP_ALL;
                cidtm_pkg::CIDTM_SLOT_TAG2: keep_of = `CIDTM_EXT_KEEP_ALL;
                cidtm_pkg::CIDTM_SLOT_TAG3: keep_of = `CIDTM_EXT_KEEP_ALL;
                cidtm_pkg::CIDTM_SLOT_TAG4: keep_of = `CIDTM_EXT_KEEP_ALL;
                cidtm_pkg::CIDTM_SLOT_MSK1: keep_of = `CIDTM_EXT_KEEP_ALL;
                default: keep_of = `CIDTM_BYTE_ZERO;
            endcase
        end else begin
            case (slot)
                cidtm_pkg::CIDTM_SLOT_TAG1: keep_of = `CIDTM_STD_KEEP_TAG_ONE;
                cidtm_pkg::CIDTM_SLOT_TAG2: keep_of = `CIDTM_STD_KEEP_TAG_TWO;
                cidtm_pkg::CIDTM_SLOT_TAG3: keep_of = `CIDTM_STD_KEEP_TAG_THREE;
                cidtm_pkg::CIDTM_SLOT_TAG4: keep_of = `CIDTM_STD_KEEP_TAG_FOUR;
                cidtm_pkg::CIDTM_SLOT_MSK1: keep_of = `CIDTM_STD_KEEP_MASK_ONE;
                default: keep_of = `CIDTM_BYTE_ZERO;
            endcase
        end
    endfunction : keep_of

    // the same five addresses are read in either layout
    assign cur_fmt = obj_ext_fmt ? cidtm_pkg::CIDTM_FMT_EXT : cidtm_pkg::CIDTM_FMT_STD;
    assign obj_ok = (32'(obj_sel) < NUM_OBJ);
    assign wr_slot = slot_of(sfr_addr);
    assign rd_slot = wr_slot;
    assign wr_keep = keep_of(wr_slot, cur_fmt);
    // lets the core's SFR read mux pick this block
    assign sfr_hit = (rd_slot != cidtm_pkg::CIDTM_SLOT_NONE);

    // an out-of-range object reads as zero instead of indexing past the array
    assign cur_tag_one = obj_ok ? tag_one_mem[obj_sel] : `CIDTM_BYTE_ZERO;
    assign cur_tag_two = obj_ok ? tag_two_mem[obj_sel] : `CIDTM_BYTE_ZERO;
    assign cur_tag_three = obj_ok ? tag_three_mem[obj_sel] : `CIDTM_BYTE_ZERO;
    assign cur_tag_four = obj_ok ? tag_four_mem[obj_sel] : `CIDTM_BYTE_ZERO;
    assign cur_mask_one = obj_ok ? mask_one_mem[obj_sel] : `CIDTM_BYTE_ZERO;

    // write path: reserved positions of the active layout keep their old
    // content, so a stray one from software never reaches the datapath
    always_ff @(posedge core_clk) begin
        if (sfr_wr && obj_ok && wr_slot == cidtm_pkg::CIDTM_SLOT_TAG1) begin
            tag_one_mem[obj_sel] <= (sfr_wdata & wr_keep) | (cur_tag_one & ~wr_keep);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sfr_wr && obj_ok && wr_slot == cidtm_pkg::CIDTM_SLOT_TAG2) begin
            tag_two_mem[obj_sel] <= (sfr_wdata & wr_keep) | (cur_tag_two & ~wr_keep);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sfr_wr && obj_ok && wr_slot == cidtm_pkg::CIDTM_SLOT_TAG3) begin
            tag_three_mem[obj_sel] <= (sfr_wdata & wr_keep) | (cur_tag_three & ~wr_keep);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sfr_wr && obj_ok && wr_slot == cidtm_pkg::CIDTM_SLOT_TAG4) begin
            tag_four_mem[obj_sel] <= (sfr_wdata & wr_keep) | (cur_tag_four & ~wr_keep);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sfr_wr && obj_ok && wr_slot == cidtm_pkg::CIDTM_SLOT_MSK1) begin
            mask_one_mem[obj_sel] <= sfr_wdata & wr_keep;
        end
    end

    // read path: reserved positions read as zero, one legal choice of "any value"
    always_comb begin
        case (rd_slot)
            cidtm_pkg::CIDTM_SLOT_TAG1: nxt_rdata = cur_tag_one & keep_of(rd_slot, cur_fmt);
            cidtm_pkg::CIDTM_SLOT_TAG2: nxt_rdata = cur_tag_two & keep_of(rd_slot, cur_fmt);
            cidtm_pkg::CIDTM_SLOT_TAG3: nxt_rdata = cur_tag_three & keep_of(rd_slot, cur_fmt);
            cidtm_pkg::CIDTM_SLOT_TAG4: nxt_rdata = cur_tag_four & keep_of(rd_slot, cur_fmt);
            cidtm_pkg::CIDTM_SLOT_MSK1: nxt_rdata = cur_mask_one & keep_of(rd_slot, cur_fmt);
            default: nxt_rdata = `CIDTM_BYTE_ZERO;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sfr_rdata_ff <= `CIDTM_BYTE_ZERO;
        end else if (sfr_rd) begin
            sfr_rdata_ff <= nxt_rdata;
        end
    end

    // identifier as the frame datapath sees it, per layout
    always_comb begin
        if (cur_fmt == cidtm_pkg::CIDTM_FMT_EXT) begin
            nxt_id = {cur_tag_one, cur_tag_two, cur_tag_three,
                      cur_tag_four[`CIDTM_EXT_LOW_MSB:`CIDTM_EXT_LOW_LSB]};
            nxt_rb1 = cur_tag_four[`CIDTM_BIT_RB1];
        end else begin
            nxt_id = {`CIDTM_STD_PAD, cur_tag_one,
                      cur_tag_two[`CIDTM_STD_LOW_MSB:`CIDTM_STD_LOW_LSB]};
            nxt_rb1 = 1'b0;
        end
    end

    // the view follows the stored bytes; it only means something once software
    // has loaded them, since the bank itself has no reset value
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sel_identifier_tag_bits_ff <= `CIDTM_ID_ZERO;
        end else begin
            sel_identifier_tag_bits_ff <= nxt_id;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sel_remote_request_tag_ff <= 1'b0;
            sel_reserved_bit1_tag_ff <= 1'b0;
            sel_reserved_bit0_tag_ff <= 1'b0;
        end else begin
            sel_remote_request_tag_ff <= cur_tag_four[`CIDTM_BIT_RTR];
            sel_reserved_bit1_tag_ff <= nxt_rb1;
            sel_reserved_bit0_tag_ff <= cur_tag_four[`CIDTM_BIT_RB0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sel_identifier_mask_bits_std_ff <= `CIDTM_BYTE_ZERO;
        end else begin
            sel_identifier_mask_bits_std_ff <= cur_mask_one;
        end
    end

    // tag byte one and mask byte one cover the top eight identifier bits in
    // both layouts, so one comparator serves either format
    cidtm_mask_cmp #(
        .WIDTH(8)
    ) u_top_cmp (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .cmp_req(rx_cmp_req),
        .rx_bits(rx_id_top),
        .tag_bits(cur_tag_one),
        .mask_bits(cur_mask_one),
        .hit_ff(id_top_match_ff),
        .done_ff(id_top_match_valid_ff)
    );

endmodule : cidtm_regs

// ---- cidtm_regs_bench.sv ----
// self-checking bench for the identifier tag/mask bank
`timescale 1ns/1ps
`include "cidtm_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module cidtm_regs_bench;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [3:0] obj_sel = 4'h3;
    logic obj_ext_fmt = 1'b1;
    logic rx_cmp_req = 1'b0;
    logic [7:0] rx_id_top = 8'h00;
    logic [7:0] sfr_rdata_ff;
    logic sfr_hit;
    logic id_top_match_ff;
    logic id_top_match_valid_ff;
    logic [28:0] sel_id;
    logic sel_rtr;
    logic sel_rb1;
    logic sel_rb0;
    logic [7:0] sel_msk;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;

    cidtm_regs #(.NUM_OBJ(15), .OBJ_W(4)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_ff(sfr_rdata_ff), .sfr_hit(sfr_hit),
        .obj_sel(obj_sel), .obj_ext_fmt(obj_ext_fmt), .rx_cmp_req(rx_cmp_req), .rx_id_top(rx_id_top),
        .id_top_match_ff(id_top_match_ff), .id_top_match_valid_ff(id_top_match_valid_ff),
        .sel_identifier_tag_bits_ff(sel_id), .sel_remote_request_tag_ff(sel_rtr),
        .sel_reserved_bit1_tag_ff(sel_rb1), .sel_reserved_bit0_tag_ff(sel_rb0),
        .sel_identifier_mask_bits_std_ff(sel_msk));

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic end_sim;
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        #1;
        `CHK(sfr_rdata_ff, e)
    endtask : rd

    task automatic cmp(input logic [7:0] v, input logic e);
        @(posedge core_clk);
        rx_cmp_req <= 1'b1;
        rx_id_top <= v;
        @(posedge core_clk);
        rx_cmp_req <= 1'b0;
        #1;
        `CHK(id_top_match_valid_ff, 1'b1)
        `CHK(id_top_match_ff, e)
    endtask : cmp

    // the selected view follows a format or object change one edge later; the task waits two edges
    task automatic sel(input logic x, input logic [3:0] o);
        @(posedge core_clk);
        obj_ext_fmt <= x;
        obj_sel <= o;
        repeat (2) @(posedge core_clk);
        #1;
    endtask : sel

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            end_sim();
        end
    end

    initial begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        wr(8'hBC, 8'hA5);
        wr(8'hBD, 8'h3C);
        wr(8'hBE, 8'h96);
        wr(8'hBF, 8'h5F);
        wr(8'hC4, 8'h0F);
        rd(8'hBC, 8'hA5);
        rd(8'hBD, 8'h3C);
        rd(8'hBE, 8'h96);
        rd(8'hBF, 8'h5F);
        `CHK(sel_id, {8'hA5, 8'h3C, 8'h96, 5'h0B})
        `CHK({sel_rtr, sel_rb1, sel_rb0}, 3'h7)
        sel(1'b0, 4'h3);
        `CHK(sel_id, {18'h00000, 8'hA5, 3'h1})
        `CHK({sel_rtr, sel_rb1, sel_rb0}, 3'h5)
        wr(8'hBC, 8'hA5);
        rd(8'hBC, 8'hA5);
        rd(8'hBD, 8'h20);
        rd(8'hBE, 8'h00);
        rd(8'hBF, 8'h05);
        wr(8'hBD, 8'hE0);
        rd(8'hBD, 8'hE0);
        wr(8'hBF, 8'h00);
        rd(8'hBF, 8'h00);
        rd(8'hC4, 8'h0F);
        `CHK(sel_msk, 8'h0F)
        `CHK(sfr_hit, 1'b1)
        cmp(8'h55, 1'b1);
        cmp(8'hA4, 1'b0);
        wr(8'hC4, 8'h00);
        cmp(8'h5A, 1'b1);
        wr(8'hC4, 8'hFF);
        cmp(8'hA5, 1'b1);
        cmp(8'h25, 1'b0);
        sel(1'b1, 4'h3);
        rd(8'hBD, 8'hFC);
        rd(8'hBF, 8'h5A);
        sel(1'b1, 4'h4);
        wr(8'hBC, 8'h11);
        rd(8'hBC, 8'h11);
        sel(1'b1, 4'hF);
        wr(8'hBE, 8'h77);
        rd(8'hBE, 8'h00);
        sel(1'b1, 4'h3);
        rd(8'hBC, 8'hA5);
        wr(8'hC0, 8'hFF);
        rd(8'hC0, 8'h00);
        `CHK(sfr_hit, 1'b0)
        @(posedge core_clk);
        sys_rst <= 1'b1;
        @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        `CHK(sfr_rdata_ff, 8'h00)
        `CHK(sel_id, 29'h00000000)
        `CHK({sel_rtr, sel_rb1, sel_rb0, sel_msk, id_top_match_ff, id_top_match_valid_ff}, 13'h0000)
        wr(8'hBC, 8'h3C);
        rd(8'hBC, 8'h3C);
        end_sim();
    end
endmodule : cidtm_regs_bench

bind cidtm_regs cidtm_regs_monitor #(.OBJ_W(OBJ_W)) u_mon (.core_clk(core_clk), .sys_rst(sys_rst),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_ff(sfr_rdata_ff),
    .sfr_hit(sfr_hit), .obj_sel(obj_sel), .obj_ext_fmt(obj_ext_fmt), .rx_cmp_req(rx_cmp_req),
    .rx_id_top(rx_id_top), .id_top_match_ff(id_top_match_ff), .id_top_match_valid_ff(id_top_match_valid_ff),
    .sel_identifier_tag_bits_ff(sel_identifier_tag_bits_ff), .sel_remote_request_tag_ff(sel_remote_request_tag_ff),
    .sel_reserved_bit1_tag_ff(sel_reserved_bit1_tag_ff), .sel_reserved_bit0_tag_ff(sel_reserved_bit0_tag_ff),
    .sel_identifier_mask_bits_std_ff(sel_identifier_mask_bits_std_ff));

// ---- cidtm_regs_monitor.sv ----
// concurrent checks on the ports of the identifier tag/mask bank
`timescale 1ns/1ps
`include "cidtm_params.svh"

module cidtm_regs_monitor #(
    parameter int OBJ_W = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register access
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata_ff,
    input wire logic sfr_hit,
    // object selection
    input wire logic [OBJ_W-1:0] obj_sel,
    input wire logic obj_ext_fmt,
    // acceptance compare
    input wire logic rx_cmp_req,
    input wire logic [7:0] rx_id_top,
    input wire logic id_top_match_ff,
    input wire logic id_top_match_valid_ff,
    // selected view
    input wire logic [28:0] sel_identifier_tag_bits_ff,
    input wire logic sel_remote_request_tag_ff,
    input wire logic sel_reserved_bit1_tag_ff,
    input wire logic sel_reserved_bit0_tag_ff,
    input wire logic [7:0] sel_identifier_mask_bits_std_ff
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [7:0] top_tag;
    // the view lags the storage by one cycle, so the compare checks need a quiet cycle before them
    assign top_tag = obj_ext_fmt ? sel_identifier_tag_bits_ff[28:21] : sel_identifier_tag_bits_ff[10:3];

    AST_STD_TAG1_VIEW: assert property (
        sfr_wr && sfr_addr == `CIDTM_ADDR_TAG_ONE && !obj_ext_fmt ##1 !obj_ext_fmt && $stable(obj_sel)
        |=> sel_identifier_tag_bits_ff[10:3] == $past(sfr_wdata, 2)) else $error("std tag one view wrong");
    AST_STD_TAG2_RD: assert property (sfr_rd && !obj_ext_fmt && sfr_addr == `CIDTM_ADDR_TAG_TWO
        |=> sfr_rdata_ff[4:0] == 5'h00) else $error("std tag two reserved read not zero");
    AST_STD_TAG3_RD: assert property (sfr_rd && !obj_ext_fmt && sfr_addr == `CIDTM_ADDR_TAG_THREE
        |=> sfr_rdata_ff == 8'h00) else $error("std tag three read not zero");
    AST_STD_TAG4_RD: assert property (sfr_rd && !obj_ext_fmt && sfr_addr == `CIDTM_ADDR_TAG_FOUR
        |=> (sfr_rdata_ff & 8'hFA) == 8'h00) else $error("std tag four reserved read not zero");
    AST_EXT_TAG4_VIEW: assert property (
        sfr_wr && sfr_addr == `CIDTM_ADDR_TAG_FOUR && obj_ext_fmt ##1 obj_ext_fmt && $stable(obj_sel)
        |=> {sel_identifier_tag_bits_ff[4:0], sel_remote_request_tag_ff, sel_reserved_bit1_tag_ff,
        sel_reserved_bit0_tag_ff} == $past(sfr_wdata, 2)) else $error("ext tag four view wrong");
    AST_MASK1_VIEW: assert property (sfr_wr && sfr_addr == `CIDTM_ADDR_MASK_ONE ##1 $stable(obj_sel)
        |=> sel_identifier_mask_bits_std_ff == $past(sfr_wdata, 2)) else $error("mask one view wrong");
    AST_MATCH: assert property (
        rx_cmp_req && !$past(sys_rst) && !$past(sfr_wr) && $stable(obj_sel) && $stable(obj_ext_fmt)
        |=> id_top_match_ff == ((($past(rx_id_top) ^ $past(top_tag)) & $past(sel_identifier_mask_bits_std_ff))
        == 8'h00)) else $error("masked compare result wrong");
    AST_VALID: assert property (!$past(sys_rst) |-> id_top_match_valid_ff == $past(rx_cmp_req))
        else $error("compare valid not one cycle after request");
    AST_STD_PAD: assert property (!$past(sys_rst) && !$past(obj_ext_fmt)
        |-> sel_identifier_tag_bits_ff[28:11] == 18'h00000 && !sel_reserved_bit1_tag_ff)
        else $error("std view carries ext bits");

    CV_MATCH: cover property (rx_cmp_req ##1 id_top_match_ff);
    CV_UNMAPPED: cover property (sfr_rd && !sfr_hit);
    CV_STD_WR: cover property (sfr_wr && !obj_ext_fmt && sfr_addr == `CIDTM_ADDR_TAG_TWO);
endmodule : cidtm_regs_monitor
